// *** logic/fbp_pkg.sv ***
`default_nettype none
package fbp_pkg;

    // Frame geometry of the input image seen by the master.
    localparam int FBP_MAX_BLK = 12;
    localparam int FBP_BASE_BYTES = 32;
    localparam int FBP_BLK_BYTES = 16;
    localparam int FBP_BLK_W = 128;
    localparam int FBP_ADDR_W = 8;
    localparam int FBP_CNT_W = 4;
    localparam int FBP_FIFO_DEPTH = 4;

    // Measurement sources and channel count.
    localparam int FBP_NUM_SRC = 5;
    localparam int FBP_NUM_CH = 4;
    localparam int FBP_TYPE_W = 4;

    // Byte positions of four-byte fields inside a block.
    localparam int FBP_OFS_Q0 = 0;
    localparam int FBP_OFS_Q1 = 4;
    localparam int FBP_OFS_Q2 = 8;
    localparam int FBP_OFS_Q3 = 12;

    // Byte positions of two-byte fields inside a block.
    localparam int FBP_OFS_D0 = 0;
    localparam int FBP_OFS_D1 = 2;
    localparam int FBP_OFS_D2 = 4;
    localparam int FBP_OFS_D3 = 6;
    localparam int FBP_OFS_D4 = 8;
    localparam int FBP_OFS_D5 = 10;
    localparam int FBP_OFS_D6 = 12;

    // Reset values of the snapshot and output registers.
    localparam logic [31:0] FBP_RST_WORD = 32'h0000_0000;
    localparam logic [FBP_BLK_W-1:0] FBP_RST_BLK = '0;

    // Content type of a configurable data block.
    typedef enum logic [FBP_TYPE_W-1:0] {
        FBP_T_UNUSED,
        FBP_T_GROSS,
        FBP_T_NET,
        FBP_T_DISP,
        FBP_T_FLOW,
        FBP_T_SIGNAL,
        FBP_T_LEVEL,
        FBP_T_SETP,
        FBP_T_INPUT,
        FBP_T_OUTPUT,
        FBP_T_IO_INT,
        FBP_T_LVSP_INT,
        FBP_T_AOUT_FLT,
        FBP_T_AOUT12_INT,
        FBP_T_AOUT34_INT
    } fbp_type_e;

    // Number format of a block.
    typedef enum logic {
        FBP_FMT_FLOAT,
        FBP_FMT_INT
    } fbp_fmt_e;

    // Packer sequencer states.
    typedef enum logic {
        FBP_S_IDLE,
        FBP_S_BUILD
    } fbp_state_e;

endpackage : fbp_pkg
`default_nettype wire

// *** logic/fbp_stream_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface fbp_stream_if #(
    parameter int W = 8
);
    logic valid;
    logic ready;
    logic [W-1:0] data;

    // The producer drives valid and data, the consumer drives ready.
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : fbp_stream_if
`default_nettype wire

// *** logic/fbp_fifo.sv ***
`timescale 1ns/1ns
`default_nettype none
module fbp_fifo #(
    parameter int W = 8,
    parameter int DEPTH = fbp_pkg::FBP_FIFO_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    fbp_stream_if.snk s_in,
    fbp_stream_if.src s_out
);
    import fbp_pkg::*;

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // The pointer arithmetic needs a power-of-two depth of at least two.
    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
        $error("fbp_fifo depth must be a power of two of at least two.");
    end

    logic [W-1:0] mem_q [DEPTH];
    logic [PW:0] wr_q;
    logic [PW:0] rd_q;
    wire full = (wr_q[PW] != rd_q[PW]) && (wr_q[PW-1:0] == rd_q[PW-1:0]);
    wire empty = (wr_q == rd_q);
    wire do_wr = s_in.valid && !full;
    wire do_rd = s_out.ready && !empty;

    // Handshake flags follow the fill level directly.
    assign s_in.ready = !full;
    assign s_out.valid = !empty;
    assign s_out.data = mem_q[rd_q[PW-1:0]];

    // Pointers advance only on an accepted handshake.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_q + (PW+1)'(do_wr);
            rd_q <= rd_q + (PW+1)'(do_rd);
        end
    end

    // Storage is written without reset; empty slots are never read out.
    always_ff @(posedge i_clk) begin
        if (do_wr) begin
            mem_q[wr_q[PW-1:0]] <= s_in.data;
        end
    end

endmodule : fbp_fifo
`default_nettype wire

// *** logic/fbp_layout.sv ***
`timescale 1ns/1ns
`default_nettype none
module fbp_layout (
    input wire logic [fbp_pkg::FBP_TYPE_W-1:0] i_type,
    input wire logic i_fmt,
    input wire logic [31:0] i_err,
    input wire logic [31:0] i_stat,
    input wire logic [31:0] i_fval,
    input wire logic [31:0] i_ival,
    input wire logic [15:0] i_dec,
    input wire logic [31:0] i_level,
    input wire logic [15:0] i_setp,
    input wire logic [47:0] i_din,
    input wire logic [47:0] i_dout,
    input wire logic [3:0][31:0] i_aout,
    output logic [fbp_pkg::FBP_BLK_W-1:0] o_blk
);
    import fbp_pkg::*;

    // Byte 0 of the block sits in the top eight bits, so fields go out MSB first.
    function automatic logic [FBP_BLK_W-1:0] put32(input logic [FBP_BLK_W-1:0] b, input int ofs,
                                                  input logic [31:0] v);
        logic [FBP_BLK_W-1:0] r;
        r = b;
        r[FBP_BLK_W-1-8*ofs -: 32] = v;
        return r;
    endfunction : put32

    function automatic logic [FBP_BLK_W-1:0] put16(input logic [FBP_BLK_W-1:0] b, input int ofs,
                                                  input logic [15:0] v);
        logic [FBP_BLK_W-1:0] r;
        r = b;
        r[FBP_BLK_W-1-8*ofs -: 16] = v;
        return r;
    endfunction : put16

    wire fbp_type_e ty = fbp_type_e'(i_type);
    wire is_int = (i_fmt == FBP_FMT_INT);

    // Builds one block; every byte not written stays zero.
    always_comb begin
        o_blk = FBP_RST_BLK;
        unique case (ty)
            FBP_T_GROSS, FBP_T_NET, FBP_T_DISP, FBP_T_FLOW, FBP_T_SIGNAL: begin
                if (is_int) begin
                    o_blk = put16(o_blk, FBP_OFS_D0, i_err[15:0]);
                    o_blk = put16(o_blk, FBP_OFS_D1, i_stat[15:0]);
                    o_blk = put32(o_blk, FBP_OFS_Q1, i_ival);
                    o_blk = put16(o_blk, FBP_OFS_D4, i_dec);
                end else begin
                    o_blk = put32(o_blk, FBP_OFS_Q0, i_err);
                    o_blk = put32(o_blk, FBP_OFS_Q1, i_stat);
                    o_blk = put32(o_blk, FBP_OFS_Q2, i_fval);
                end
            end
            FBP_T_LEVEL: begin
                o_blk = put32(o_blk, FBP_OFS_Q0, {16'h0000, i_level[15:0]});
                o_blk = put32(o_blk, FBP_OFS_Q1, {16'h0000, i_level[31:16]});
            end
            FBP_T_SETP: begin
                o_blk = put32(o_blk, FBP_OFS_Q0, {24'h000000, i_setp[7:0]});
                o_blk = put32(o_blk, FBP_OFS_Q1, {24'h000000, i_setp[15:8]});
            end
            FBP_T_INPUT: begin
                o_blk = put32(o_blk, FBP_OFS_Q0, {16'h0000, i_din[15:0]});
                o_blk = put32(o_blk, FBP_OFS_Q1, {16'h0000, i_din[31:16]});
                o_blk = put32(o_blk, FBP_OFS_Q2, {16'h0000, i_din[47:32]});
            end
            FBP_T_OUTPUT: begin
                o_blk = put32(o_blk, FBP_OFS_Q0, {16'h0000, i_dout[15:0]});
                o_blk = put32(o_blk, FBP_OFS_Q1, {16'h0000, i_dout[31:16]});
                o_blk = put32(o_blk, FBP_OFS_Q2, {16'h0000, i_dout[47:32]});
            end
            FBP_T_IO_INT: begin
                o_blk = put16(o_blk, FBP_OFS_D0, i_din[15:0]);
                o_blk = put16(o_blk, FBP_OFS_D1, i_din[31:16]);
                o_blk = put16(o_blk, FBP_OFS_D2, i_din[47:32]);
                o_blk = put16(o_blk, FBP_OFS_D4, i_dout[15:0]);
                o_blk = put16(o_blk, FBP_OFS_D5, i_dout[31:16]);
                o_blk = put16(o_blk, FBP_OFS_D6, i_dout[47:32]);
            end
            FBP_T_LVSP_INT: begin
                o_blk = put16(o_blk, FBP_OFS_D0, i_level[15:0]);
                o_blk = put16(o_blk, FBP_OFS_D1, i_level[31:16]);
                o_blk = put16(o_blk, FBP_OFS_D2, {8'h00, i_setp[7:0]});
                o_blk = put16(o_blk, FBP_OFS_D3, {8'h00, i_setp[15:8]});
            end
            FBP_T_AOUT_FLT: begin
                o_blk = put32(o_blk, FBP_OFS_Q0, i_aout[0]);
                o_blk = put32(o_blk, FBP_OFS_Q1, i_aout[1]);
                o_blk = put32(o_blk, FBP_OFS_Q2, i_aout[2]);
                o_blk = put32(o_blk, FBP_OFS_Q3, i_aout[3]);
            end
            FBP_T_UNUSED, FBP_T_AOUT12_INT, FBP_T_AOUT34_INT: begin
                o_blk = FBP_RST_BLK;
            end
            default: begin
                o_blk = FBP_RST_BLK;
            end
        endcase
    end

endmodule : fbp_layout
`default_nettype wire

// *** logic/fbp_packer.sv ***
// Function
// - Each block takes one of fifteen content types.
// - Measurement block type selects gross, net, displayed, flow or transducer signal.
// - Measurement fields come from the block's configured channel.
// - Per-block format setting picks the layout; float selects four-byte fields. The code applies it to measurement blocks only.
// - Float measurement: error 0-3, status 4-7, data 8-11, MSB first.
// - Integer format setting selects the compact integer measurement layout.
// - Integer measurement: error 0-1, status 2-3, value 4-7, decimals 8-9.
// - Float level block: levels 1-16 at 0-3, 17-32 at 4-7.
// - Float setpoint block: setpoints 1-8 at 0-3, 9-16 at 4-7.
// - Float input block: three input group pairs at bytes 0, 4, 8.
// - Float output block: three output group pairs at bytes 0, 4, 8.
// - Integer I/O block: inputs at 0, 2, 4; outputs at 8, 10, 12.
// - Integer level/setpoint block: two-byte words at bytes 0, 2, 4, 6.
// - Float analog output block: four values at bytes 0, 4, 8, 12.
// - In-block byte positions are relative to the block's slot start.
// - Block N starts at byte 32 plus 16 times N minus 1.
// - A block set to not in use may carry undefined contents.
// - Integer quantities are a whole number plus a decimal-place count.
`timescale 1ns/1ns
`default_nettype none
module fbp_packer #(
    parameter int NUM_BLK = fbp_pkg::FBP_MAX_BLK,
    parameter int NUM_CH = fbp_pkg::FBP_NUM_CH,
    parameter int FIFO_DEPTH = fbp_pkg::FBP_FIFO_DEPTH,
    parameter int CH_W = (NUM_CH > 1) ? $clog2(NUM_CH) : 1
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_sample,
    input wire logic [fbp_pkg::FBP_CNT_W-1:0] i_num_blocks,
    input wire logic [NUM_BLK-1:0][fbp_pkg::FBP_TYPE_W-1:0] i_blk_type,
    input wire logic [NUM_BLK-1:0] i_blk_fmt,
    input wire logic [NUM_BLK-1:0][CH_W-1:0] i_blk_chan,
    input wire logic [NUM_CH-1:0][31:0] i_meas_err,
    input wire logic [NUM_CH-1:0][31:0] i_meas_stat,
    input wire logic [NUM_CH-1:0][fbp_pkg::FBP_NUM_SRC-1:0][31:0] i_meas_flt,
    input wire logic [NUM_CH-1:0][fbp_pkg::FBP_NUM_SRC-1:0][31:0] i_meas_int,
    input wire logic [NUM_CH-1:0][fbp_pkg::FBP_NUM_SRC-1:0][15:0] i_meas_dec,
    input wire logic [31:0] i_level,
    input wire logic [15:0] i_setp,
    input wire logic [47:0] i_din,
    input wire logic [47:0] i_dout,
    input wire logic [3:0][31:0] i_aout,
    input wire logic i_blk_ready,
    output logic o_blk_valid,
    output logic [fbp_pkg::FBP_ADDR_W-1:0] o_blk_addr,
    output logic [fbp_pkg::FBP_BLK_W-1:0] o_blk_data,
    output logic o_busy,
    output logic o_frame_done,
    output logic o_sample_miss
);
    import fbp_pkg::*;

    localparam int WORD_W = FBP_ADDR_W + FBP_BLK_W;
    localparam int SRC_W = 3;

    // Refuse block counts and channel counts the index logic cannot reach.
    if (NUM_BLK < 1 || NUM_BLK > FBP_MAX_BLK) begin : g_bad_blk
        $error("fbp_packer block count must lie between one and the image maximum.");
    end
    if (NUM_CH < 1 || (1 << CH_W) < NUM_CH) begin : g_bad_ch
        $error("fbp_packer channel select is too narrow for the channel count.");
    end

    // Start byte of a block slot in the input image, from its zero-based index.
    function automatic logic [FBP_ADDR_W-1:0] slot_addr(input logic [FBP_CNT_W-1:0] idx);
        return FBP_ADDR_W'(FBP_BASE_BYTES + FBP_BLK_BYTES * int'(idx));
    endfunction : slot_addr

    // Snapshot of configuration and every data input.
    logic [NUM_BLK-1:0][FBP_TYPE_W-1:0] type_q;
    logic [NUM_BLK-1:0] fmt_q;
    logic [NUM_BLK-1:0][CH_W-1:0] chan_q;
    logic [NUM_CH-1:0][31:0] err_q;
    logic [NUM_CH-1:0][31:0] stat_q;
    logic [NUM_CH-1:0][FBP_NUM_SRC-1:0][31:0] flt_q;
    logic [NUM_CH-1:0][FBP_NUM_SRC-1:0][31:0] int_q;
    logic [NUM_CH-1:0][FBP_NUM_SRC-1:0][15:0] dec_q;
    logic [31:0] level_q;
    logic [15:0] setp_q;
    logic [47:0] din_q;
    logic [47:0] dout_q;
    logic [3:0][31:0] aout_q;

    // Sequencer state.
    fbp_state_e state_q;
    fbp_state_e state_d;
    logic [FBP_CNT_W-1:0] idx_q;
    logic [FBP_CNT_W-1:0] idx_d;
    logic [FBP_CNT_W-1:0] last_q;

    // Output stage.
    logic valid_q;
    logic [FBP_ADDR_W-1:0] addr_q;
    logic [FBP_BLK_W-1:0] data_q;
    logic busy_q;
    logic done_q;
    logic miss_q;

    fbp_stream_if #(.W(WORD_W)) push_if ();
    fbp_stream_if #(.W(WORD_W)) pop_if ();

    // A frame starts only from idle; a request while busy is reported and dropped.
    wire start = i_sample && (state_q == FBP_S_IDLE);
    wire miss = i_sample && (state_q != FBP_S_IDLE);
    wire has_blocks = (i_num_blocks != '0);
    wire [FBP_CNT_W-1:0] num_clip = (int'(i_num_blocks) > NUM_BLK) ? FBP_CNT_W'(NUM_BLK) : i_num_blocks;
    wire push_fire = push_if.valid && push_if.ready;
    wire at_last = (idx_q == last_q);

    // Decode of the block being built from the snapshot.
    wire [FBP_TYPE_W-1:0] cur_type = type_q[idx_q];
    wire cur_fmt = fmt_q[idx_q];
    wire [CH_W-1:0] cur_chan = chan_q[idx_q];
    wire chan_ok = (int'(cur_chan) < NUM_CH);
    wire is_meas = (cur_type >= FBP_T_GROSS) && (cur_type <= FBP_T_SIGNAL);
    wire [SRC_W-1:0] src_idx = is_meas ? SRC_W'(cur_type - FBP_T_GROSS) : '0;
    wire [31:0] sel_err = chan_ok ? err_q[cur_chan] : FBP_RST_WORD;
    wire [31:0] sel_stat = chan_ok ? stat_q[cur_chan] : FBP_RST_WORD;
    wire [31:0] sel_fval = chan_ok ? flt_q[cur_chan][src_idx] : FBP_RST_WORD;
    wire [31:0] sel_ival = chan_ok ? int_q[cur_chan][src_idx] : FBP_RST_WORD;
    wire [15:0] sel_dec = chan_ok ? dec_q[cur_chan][src_idx] : 16'h0000;
    wire [FBP_BLK_W-1:0] cur_blk;

    fbp_layout u_layout (
        .i_type(cur_type),
        .i_fmt(cur_fmt),
        .i_err(sel_err),
        .i_stat(sel_stat),
        .i_fval(sel_fval),
        .i_ival(sel_ival),
        .i_dec(sel_dec),
        .i_level(level_q),
        .i_setp(setp_q),
        .i_din(din_q),
        .i_dout(dout_q),
        .i_aout(aout_q),
        .o_blk(cur_blk)
    );

    // The FIFO absorbs a stalled master; a full FIFO holds the sequencer.
    assign push_if.valid = (state_q == FBP_S_BUILD);
    assign push_if.data = {slot_addr(idx_q), cur_blk};

    fbp_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .s_in(push_if.snk),
        .s_out(pop_if.src)
    );

    // The output register refills when empty or when the master takes its word.
    wire out_free = !valid_q || i_blk_ready;
    wire out_load = out_free && pop_if.valid;
    assign pop_if.ready = out_free;

    // Next state: walk the configured blocks once per sample request.
    always_comb begin
        state_d = state_q;
        idx_d = idx_q;
        unique case (state_q)
            FBP_S_IDLE: begin
                if (start && has_blocks) begin
                    state_d = FBP_S_BUILD;
                    idx_d = '0;
                end
            end
            FBP_S_BUILD: begin
                if (push_fire) begin
                    idx_d = idx_q + FBP_CNT_W'(1);
                    if (at_last) begin
                        state_d = FBP_S_IDLE;
                        idx_d = '0;
                    end
                end
            end
        endcase
    end

    // Sequencer registers and the frame status flags.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_q <= FBP_S_IDLE;
            idx_q <= '0;
            last_q <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            miss_q <= 1'b0;
        end else begin
            state_q <= state_d;
            idx_q <= idx_d;
            if (start) begin
                last_q <= num_clip - FBP_CNT_W'(1);
            end
            busy_q <= (state_d == FBP_S_BUILD);
            done_q <= (start && !has_blocks) || (push_fire && at_last);
            miss_q <= miss;
        end
    end

    // One snapshot per frame keeps every multi-byte field coherent.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            type_q <= '0;
            fmt_q <= '0;
            chan_q <= '0;
            err_q <= '0;
            stat_q <= '0;
            flt_q <= '0;
            int_q <= '0;
            dec_q <= '0;
            level_q <= FBP_RST_WORD;
            setp_q <= '0;
            din_q <= '0;
            dout_q <= '0;
            aout_q <= '0;
        end else if (start) begin
            type_q <= i_blk_type;
            fmt_q <= i_blk_fmt;
            chan_q <= i_blk_chan;
            err_q <= i_meas_err;
            stat_q <= i_meas_stat;
            flt_q <= i_meas_flt;
            int_q <= i_meas_int;
            dec_q <= i_meas_dec;
            level_q <= i_level;
            setp_q <= i_setp;
            din_q <= i_din;
            dout_q <= i_dout;
            aout_q <= i_aout;
        end
    end

    // Output word register; it holds steady while the master stalls.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            valid_q <= 1'b0;
            addr_q <= '0;
            data_q <= FBP_RST_BLK;
        end else begin
            if (out_load) begin
                addr_q <= pop_if.data[WORD_W-1 -: FBP_ADDR_W];
                data_q <= pop_if.data[FBP_BLK_W-1:0];
            end
            if (out_free) begin
                valid_q <= pop_if.valid;
            end
        end
    end

    // Every output is a register.
    assign o_blk_valid = valid_q;
    assign o_blk_addr = addr_q;
    assign o_blk_data = data_q;
    assign o_busy = busy_q;
    assign o_frame_done = done_q;
    assign o_sample_miss = miss_q;

endmodule : fbp_packer
`default_nettype wire

// *** bench/fbp_packer_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none
module fbp_packer_assertions (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_sample,
    input wire logic [fbp_pkg::FBP_CNT_W-1:0] i_num_blocks,
    input wire logic i_blk_ready,
    input wire logic o_blk_valid,
    input wire logic [fbp_pkg::FBP_ADDR_W-1:0] o_blk_addr,
    input wire logic [fbp_pkg::FBP_BLK_W-1:0] o_blk_data,
    input wire logic o_busy,
    input wire logic o_frame_done,
    input wire logic o_sample_miss
);
    import fbp_pkg::*;
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);

    // A frame request that finds the packer quiet.
    sequence quiet_start;
        i_sample && !o_busy && !$past(o_busy) && !$past(i_sample) && !o_frame_done;
    endsequence
    // One word taken and the next word offered.
    sequence word_pair;
        o_blk_valid && i_blk_ready ##1 o_blk_valid;
    endsequence

    stall_hold_a: assert property (
        o_blk_valid && !i_blk_ready |=> o_blk_valid && $stable(o_blk_addr) && $stable(o_blk_data))
        else $error("Word changed while stalled.");
    slot_align_a: assert property (
        o_blk_valid |-> o_blk_addr[3:0] == 4'h0 && o_blk_addr >= 8'h20 && o_blk_addr <= 8'hD0)
        else $error("Word address off a block slot.");
    first_word_a: assert property (
        quiet_start ##0 (i_num_blocks != 4'h0 && !o_blk_valid) |-> ##3 (o_blk_valid && o_blk_addr == 8'h20))
        else $error("First block not offered in time.");
    addr_step_a: assert property (
        word_pair |-> o_blk_addr == $past(o_blk_addr) + 8'h10 || o_blk_addr == 8'h20)
        else $error("Block slots out of order.");
    empty_frame_a: assert property (
        quiet_start ##0 (i_num_blocks == 4'h0) |=> o_frame_done)
        else $error("Empty frame not finished at once.");
    busy_rise_a: assert property (
        quiet_start ##0 (i_num_blocks != 4'h0) |=> o_busy)
        else $error("Busy missing after frame start.");
    miss_flag_a: assert property (
        i_sample && o_busy |=> o_sample_miss)
        else $error("Request while busy not flagged.");
    miss_cause_a: assert property (
        o_sample_miss |-> $past(i_sample))
        else $error("Miss flag without a request.");
    done_idle_a: assert property (
        o_frame_done |-> !o_busy)
        else $error("Frame done while still busy.");
endmodule : fbp_packer_assertions
bind fbp_packer fbp_packer_assertions chk (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_sample(i_sample),
    .i_num_blocks(i_num_blocks),
    .i_blk_ready(i_blk_ready),
    .o_blk_valid(o_blk_valid),
    .o_blk_addr(o_blk_addr),
    .o_blk_data(o_blk_data),
    .o_busy(o_busy),
    .o_frame_done(o_frame_done),
    .o_sample_miss(o_sample_miss)
);
`default_nettype wire

// *** bench/fbp_master_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module fbp_master_model (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [1:0] i_mode,
    output logic o_ready
);
    logic [5:0] hold_q;

    // Mode 0 takes every word, mode 1 stalls at random, mode 2 holds off 40 cycles so the buffer fills.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            hold_q <= 6'h00;
            o_ready <= 1'b0;
        end else begin
            hold_q <= (i_mode != 2'h2) ? 6'h00 : ((hold_q == 6'h28) ? hold_q : hold_q + 6'h01);
            o_ready <= (i_mode == 2'h0) || (i_mode == 2'h1 && $urandom % 3 != 0) || (hold_q == 6'h28);
        end
    end
endmodule : fbp_master_model
`default_nettype wire

// *** bench/tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb;
    import fbp_pkg::*;
    logic i_clk, i_nrst, i_sample, i_blk_ready, o_blk_valid, o_busy, o_frame_done, o_sample_miss;
    logic [1:0] mode;
    logic [3:0] i_num_blocks;
    logic [11:0][3:0] i_blk_type;
    logic [11:0] i_blk_fmt;
    logic [11:0][1:0] i_blk_chan;
    logic [3:0][31:0] i_meas_err, i_meas_stat, i_aout;
    logic [3:0][4:0][31:0] i_meas_flt, i_meas_int;
    logic [3:0][4:0][15:0] i_meas_dec;
    logic [31:0] i_level;
    logic [15:0] i_setp;
    logic [47:0] i_din, i_dout;
    logic [7:0] o_blk_addr;
    logic [127:0] o_blk_data;
    logic [135:0] exp_q[$];
    int errors, n_compared, n_done, n_miss, miss_exp;

    fbp_packer DUT (.*);
    fbp_master_model far_end (.i_clk(i_clk), .i_nrst(i_nrst), .i_mode(mode), .o_ready(i_blk_ready));

    // The 125 MHz system clock.
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    task automatic check(input logic [135:0] seen, input logic [135:0] want);
        n_compared++;
        if (seen !== want) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, want);
        end
    endtask : check

    task automatic results;
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : results

    // Block contents the master should read, built from the inputs seen at the start edge.
    function automatic logic [127:0] exp_blk(input int k);
        logic [1:0] c;
        int s;
        c = i_blk_chan[k];
        s = int'(i_blk_type[k]) - 1;
        case (i_blk_type[k])
            4'h1, 4'h2, 4'h3, 4'h4, 4'h5: exp_blk = i_blk_fmt[k] ?
                {i_meas_err[c][15:0], i_meas_stat[c][15:0], i_meas_int[c][s], i_meas_dec[c][s], 48'h0}
                : {i_meas_err[c], i_meas_stat[c], i_meas_flt[c][s], 32'h0};
            4'h6: exp_blk = {16'h0, i_level[15:0], 16'h0, i_level[31:16], 64'h0};
            4'h7: exp_blk = {24'h0, i_setp[7:0], 24'h0, i_setp[15:8], 64'h0};
            4'h8: exp_blk = {16'h0, i_din[15:0], 16'h0, i_din[31:16], 16'h0, i_din[47:32], 32'h0};
            4'h9: exp_blk = {16'h0, i_dout[15:0], 16'h0, i_dout[31:16], 16'h0, i_dout[47:32], 32'h0};
            4'hA: exp_blk = {i_din[15:0], i_din[31:16], i_din[47:32], 16'h0,
                             i_dout[15:0], i_dout[31:16], i_dout[47:32], 16'h0};
            4'hB: exp_blk = {i_level[15:0], i_level[31:16], 8'h0, i_setp[7:0], 8'h0, i_setp[15:8], 64'h0};
            4'hC: exp_blk = {i_aout[0], i_aout[1], i_aout[2], i_aout[3]};
            default: exp_blk = '0;
        endcase
    endfunction : exp_blk

    task automatic scramble;
        for (int c = 0; c < 4; c++) begin
            i_meas_err[c] <= $urandom;
            i_meas_stat[c] <= $urandom;
            i_aout[c] <= $urandom;
            for (int s = 0; s < 5; s++) begin
                i_meas_flt[c][s] <= $urandom;
                i_meas_int[c][s] <= $urandom;
                i_meas_dec[c][s] <= 16'($urandom);
            end
        end
        i_level <= $urandom;
        i_setp <= 16'($urandom);
        i_din <= 48'({$urandom, $urandom});
        i_dout <= 48'({$urandom, $urandom});
    endtask : scramble

    // Starts one frame, notes its blocks, then disturbs every input but the block types and count until the frame is done.
    task automatic frame(input logic [3:0] n, input int base, input logic fmt);
        int d0;
        @(posedge i_clk);
        i_num_blocks <= n;
        for (int k = 0; k < 12; k++) begin
            i_blk_type[k] <= 4'((base < 0) ? $urandom % 15 : (base + k) % 15);
            i_blk_fmt[k] <= (base < 0) ? 1'($urandom) : fmt;
            i_blk_chan[k] <= 2'($urandom);
        end
        scramble();
        i_sample <= 1'b1;
        @(posedge i_clk);
        d0 = n_done;
        for (int k = 0; k < n && k < 12; k++) exp_q.push_back({8'(32 + 16 * k), exp_blk(k)});
        if (n > 4'h3) miss_exp++;
        for (int t = 0; n_done == d0; t++) begin
            i_sample <= (t == 1 && n > 4'h3);
            i_blk_fmt <= 12'($urandom);
            i_blk_chan <= 24'($urandom);
            scramble();
            if (t == 400) begin
                errors++;
                results();
            end
            @(posedge i_clk);
        end
    endtask : frame

    // Each word the master takes is matched against the oldest noted one.
    always @(negedge i_clk) begin
        if (i_nrst) begin
            n_done += int'(o_frame_done === 1'b1);
            n_miss += int'(o_sample_miss === 1'b1);
            if (o_blk_valid === 1'b1 && i_blk_ready === 1'b1) begin
                check({o_blk_addr, o_blk_data}, (exp_q.size() > 0) ? exp_q.pop_front() : 136'h0);
            end
        end
    end

    // Reset, type sweep in both formats, random stalls, an empty frame and a full buffer.
    initial begin
        {i_nrst, i_sample, mode, i_num_blocks, i_blk_type, i_blk_fmt, i_blk_chan} = '0;
        {i_meas_err, i_meas_stat, i_aout, i_meas_flt, i_meas_int, i_meas_dec} = '0;
        {i_level, i_setp, i_din, i_dout} = '0;
        {errors, n_compared, n_done, n_miss, miss_exp} = '0;
        void'($urandom(32'hB0BA));
        repeat (10) @(posedge i_clk);
        i_nrst <= 1'b1;
        for (int i = 0; i < 4; i++) frame(4'hC, i * 12, i[0]);
        mode <= 2'h1;
        repeat (8) frame(4'($urandom % 13), -1, 1'b0);
        frame(4'h0, -1, 1'b0);
        mode <= 2'h2;
        // A count above the slot maximum is clipped to twelve blocks.
        frame(4'hF, -1, 1'b0);
        for (int t = 0; t < 400 && exp_q.size() != 0; t++) @(posedge i_clk);
        check(136'(exp_q.size()), 136'h0);
        check(136'(n_miss), 136'(miss_exp));
        results();
    end
endmodule : tb
`default_nettype wire
